// ### pkg/nvm_cfg.svh
// constants of the two-wire nonvolatile memory slave
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH
`define NVM_ADDR_W    9
`define NVM_MEM_DEPTH 512
`define NVM_ID_SETUP  8'hf8
`define NVM_ID_READ   8'hf9
`define NVM_BIT_NONE  4'h0
`define NVM_BIT_FIRST 4'h1
`define NVM_BIT_LAST  4'h7
`define NVM_BIT_ACK   4'h8
`define NVM_MSB_IDX   3'h7
`define NVM_ID_FIRST  2'h0
`define NVM_ID_LAST   2'h2
`define NVM_ADDR_RST  9'h000
`define NVM_ADDR_TOP  9'h1ff
`define NVM_ADDR_ONE  9'h001
`endif

// ### pkg/nvm_pkg.sv
// types of the two-wire nonvolatile memory slave
`include "nvm_cfg.svh"
package nvm_pkg;
    typedef enum logic [2:0] {
        NVM_IDLE  = 3'h0,
        NVM_DEV   = 3'h1,
        NVM_MADDR = 3'h3,
        NVM_WR    = 3'h2,
        NVM_RD    = 3'h6,
        NVM_IDSEL = 3'h7,
        NVM_ID    = 3'h5
    } nvm_state_t;

    typedef struct packed {
        nvm_state_t             state;
        nvm_state_t             nxt;
        logic [3:0]             cnt;
        logic [7:0]             shift;
        logic [`NVM_ADDR_W-1:0] addr;
        logic                   fresh;
        logic                   pend_msb;
        logic                   ack;
        logic                   id_armed;
        logic [1:0]             id_idx;
        logic [7:0]             tx;
        logic                   start_ack;
        logic                   stop_ack;
        logic                   wp_s1;
        logic                   wp_s2;
        logic [1:0]             sel_s1;
        logic [1:0]             sel_s2;
        logic                   wr_tog;
        logic                   blk_tog;
    } nvm_link_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } nvm_drive_t;

    typedef struct packed {
        logic [2:0] wr_s;
        logic [2:0] blk_s;
        logic       wr_pulse;
        logic       blk_pulse;
    } nvm_sys_t;
endpackage : nvm_pkg

// ### rtl/nvm_i2c_slave.sv
// two-wire slave front end with 512 x 8 byte memory
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cfg.svh"

module nvm_i2c_slave #(
    parameter logic [3:0] DEV_TYPE = 4'hb,  // arbitrary value
    parameter logic [7:0] ID_BYTE0 = 8'h11, // arbitrary value
    parameter logic [7:0] ID_BYTE1 = 8'h22, // arbitrary value
    parameter logic [7:0] ID_BYTE2 = 8'h33  // arbitrary value
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var  logic sda_o,
    output var  logic sda_oe,
    input  wire logic select_pin_low,
    input  wire logic select_pin_high,
    input  wire logic write_inhibit,
    output var  logic byte_written,
    output var  logic write_blocked
);

    // ************************************************
    // functions
    // ************************************************
    function automatic logic [`NVM_ADDR_W-1:0] next_addr(input logic fresh,
                                                          input logic [`NVM_ADDR_W-1:0] a);
        next_addr = fresh ? a : a + `NVM_ADDR_ONE;
    endfunction : next_addr

    function automatic logic [7:0] id_byte(input logic [1:0] idx);
        unique case (idx)
            2'h0:    id_byte = ID_BYTE0;
            2'h1:    id_byte = ID_BYTE1;
            default: id_byte = ID_BYTE2;
        endcase
    endfunction : id_byte

    // ************************************************
    // start and stop detection on data edges
    // ************************************************
    logic start_tog_q;
    logic stop_tog_q;

    always_ff @(negedge sda_i or negedge reset_n) begin
        if (!reset_n) begin
            start_tog_q <= 1'b0;
        end else if (scl_i) begin
            start_tog_q <= ~start_tog_q;
        end
    end

    always_ff @(posedge sda_i or negedge reset_n) begin
        if (!reset_n) begin
            stop_tog_q <= 1'b0;
        end else if (scl_i) begin
            stop_tog_q <= ~stop_tog_q;
        end
    end

    // ************************************************
    // link side, rising serial clock
    // ************************************************
    nvm_pkg::nvm_link_t  l_q;
    nvm_pkg::nvm_link_t  l_d;
    logic [7:0]          mem [`NVM_MEM_DEPTH];
    logic                mem_we;
    logic [`NVM_ADDR_W-1:0] mem_wa;
    logic [7:0]          mem_wd;

    always_comb begin
        logic [7:0]             byte_in;
        logic [`NVM_ADDR_W-1:0] t;
        byte_in = {l_q.shift[6:0], sda_i};
        t = next_addr(l_q.fresh, l_q.addr);
        l_d = l_q;
        mem_we = 1'b0;
        mem_wa = t;
        mem_wd = l_q.shift;
        l_d.wp_s1 = write_inhibit;
        l_d.wp_s2 = l_q.wp_s1;
        l_d.sel_s1 = {select_pin_high, select_pin_low};
        l_d.sel_s2 = l_q.sel_s1;
        l_d.start_ack = start_tog_q;
        l_d.stop_ack = stop_tog_q;
        if (start_tog_q != l_q.start_ack) begin
            l_d.state = nvm_pkg::NVM_DEV;
            l_d.cnt = `NVM_BIT_FIRST;
            l_d.shift = {7'h00, sda_i};
            l_d.ack = 1'b0;
            if (stop_tog_q != l_q.stop_ack) begin
                l_d.id_armed = 1'b0;
            end
        end else if (stop_tog_q != l_q.stop_ack) begin
            l_d.state = nvm_pkg::NVM_IDLE;
            l_d.cnt = `NVM_BIT_NONE;
            l_d.ack = 1'b0;
            l_d.id_armed = 1'b0;
        end else begin
            if (l_q.cnt < `NVM_BIT_ACK) begin
                l_d.shift = byte_in;
                l_d.cnt = l_q.cnt + `NVM_BIT_FIRST;
            end else begin
                l_d.cnt = `NVM_BIT_NONE;
            end
            unique case (l_q.state)
                nvm_pkg::NVM_IDLE: begin
                    l_d.cnt = `NVM_BIT_NONE;
                end
                nvm_pkg::NVM_DEV: begin
                    if (l_q.cnt == `NVM_BIT_LAST) begin
                        l_d.ack = 1'b0;
                        l_d.nxt = nvm_pkg::NVM_IDLE;
                        l_d.pend_msb = byte_in[1];
                        l_d.id_armed = 1'b0;
                        if (byte_in == `NVM_ID_SETUP) begin
                            l_d.ack = 1'b1;
                            l_d.nxt = nvm_pkg::NVM_IDSEL;
                        end else if (byte_in == `NVM_ID_READ && l_q.id_armed) begin
                            l_d.ack = 1'b1;
                            l_d.nxt = nvm_pkg::NVM_ID;
                        end else if (byte_in[7:4] == DEV_TYPE && byte_in[3:2] == l_q.sel_s2) begin
                            l_d.ack = 1'b1;
                            l_d.nxt = byte_in[0] ? nvm_pkg::NVM_RD : nvm_pkg::NVM_MADDR;
                        end
                    end else if (l_q.cnt == `NVM_BIT_ACK) begin
                        l_d.state = l_q.ack ? l_q.nxt : nvm_pkg::NVM_IDLE;
                        if (l_q.ack && l_q.nxt == nvm_pkg::NVM_MADDR) begin
                            l_d.addr = {l_q.pend_msb, l_q.addr[7:0]};
                        end
                        if (l_q.ack && l_q.nxt == nvm_pkg::NVM_RD) begin
                            // buffered low byte with new msb
                            t = next_addr(l_q.fresh, {l_q.pend_msb, l_q.addr[7:0]});
                            l_d.addr = t;
                            l_d.fresh = 1'b0;
                            l_d.tx = mem[t];
                        end
                        if (l_q.ack && l_q.nxt == nvm_pkg::NVM_ID) begin
                            l_d.id_idx = `NVM_ID_FIRST;
                            l_d.tx = id_byte(`NVM_ID_FIRST);
                        end
                    end
                end
                nvm_pkg::NVM_MADDR: begin
                    if (l_q.cnt == `NVM_BIT_LAST) begin
                        // low address byte loaded and acked
                        l_d.ack = 1'b1;
                        l_d.addr = {l_q.addr[8], byte_in};
                        l_d.fresh = 1'b1;
                    end else if (l_q.cnt == `NVM_BIT_ACK) begin
                        l_d.state = nvm_pkg::NVM_WR;
                    end
                end
                nvm_pkg::NVM_WR: begin
                    if (l_q.cnt == `NVM_BIT_LAST) begin
                        l_d.ack = 1'b1;
                    end else if (l_q.cnt == `NVM_BIT_ACK) begin
                        l_d.addr = t;
                        l_d.fresh = 1'b0;
                        mem_we = ~l_q.wp_s2;
                        l_d.wr_tog = l_q.wr_tog ^ ~l_q.wp_s2;
                        l_d.blk_tog = l_q.blk_tog ^ l_q.wp_s2;
                    end
                end
                nvm_pkg::NVM_RD: begin
                    if (l_q.cnt == `NVM_BIT_ACK) begin
                        if (!sda_i) begin
                            l_d.addr = l_q.addr + `NVM_ADDR_ONE;
                            l_d.tx = mem[l_q.addr + `NVM_ADDR_ONE];
                        end else begin
                            l_d.state = nvm_pkg::NVM_IDLE;
                        end
                    end
                end
                nvm_pkg::NVM_IDSEL: begin
                    if (l_q.cnt == `NVM_BIT_LAST) begin
                        l_d.ack = 1'b1;
                    end else if (l_q.cnt == `NVM_BIT_ACK) begin
                        l_d.state = nvm_pkg::NVM_IDLE;
                        l_d.id_armed = 1'b1;
                    end
                end
                nvm_pkg::NVM_ID: begin
                    if (l_q.cnt == `NVM_BIT_ACK) begin
                        if (!sda_i) begin
                            l_d.id_idx = (l_q.id_idx == `NVM_ID_LAST) ? `NVM_ID_FIRST
                                                                      : l_q.id_idx + 2'h1;
                            l_d.tx = id_byte(l_d.id_idx);
                        end else begin
                            l_d.state = nvm_pkg::NVM_IDLE;
                        end
                    end
                end
                default: begin
                    l_d.state = nvm_pkg::NVM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_i or negedge reset_n) begin
        if (!reset_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    always_ff @(posedge scl_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ************************************************
    // link side, falling serial clock
    // ************************************************
    nvm_pkg::nvm_drive_t o_q;
    nvm_pkg::nvm_drive_t o_d;
    logic                rx_state;
    logic                tx_state;

    always_comb begin
        rx_state = l_q.state inside {nvm_pkg::NVM_DEV, nvm_pkg::NVM_MADDR,
                                     nvm_pkg::NVM_WR, nvm_pkg::NVM_IDSEL};
        tx_state = l_q.state inside {nvm_pkg::NVM_RD, nvm_pkg::NVM_ID};
        o_d.sda_o = 1'b0;
        o_d.sda_oe = 1'b0;
        if (start_tog_q != l_q.start_ack || stop_tog_q != l_q.stop_ack) begin
            o_d.sda_oe = 1'b0;
        end else if (l_q.cnt == `NVM_BIT_ACK) begin
            // ack drive, released for master ack
            o_d.sda_oe = rx_state & l_q.ack;
        end else if (tx_state) begin
            // open drain, driven on falling edge
            o_d.sda_oe = ~l_q.tx[`NVM_MSB_IDX - l_q.cnt[2:0]];
        end
    end

    always_ff @(negedge scl_i or negedge reset_n) begin
        if (!reset_n) begin
            o_q <= '0;
        end else begin
            o_q <= o_d;
        end
    end

    assign sda_o = o_q.sda_o;
    assign sda_oe = o_q.sda_oe;

    // ************************************************
    // system side, write events
    // ************************************************
    nvm_pkg::nvm_sys_t s_q;
    nvm_pkg::nvm_sys_t s_d;

    always_comb begin
        s_d.wr_s = {s_q.wr_s[1:0], l_q.wr_tog};
        s_d.blk_s = {s_q.blk_s[1:0], l_q.blk_tog};
        s_d.wr_pulse = s_q.wr_s[1] ^ s_q.wr_s[2];
        s_d.blk_pulse = s_q.blk_s[1] ^ s_q.blk_s[2];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign byte_written = s_q.wr_pulse;
    assign write_blocked = s_q.blk_pulse;

    // ************************************************
    // assertions
    // ************************************************
    sequence s_word_end;
        l_q.state == nvm_pkg::NVM_DEV && l_q.cnt == `NVM_BIT_LAST
            && start_tog_q == l_q.start_ack && stop_tog_q == l_q.stop_ack;
    endsequence

    sequence s_match;
        {l_q.shift[6:3], sda_i} != 5'h00 && l_q.shift[6:3] == DEV_TYPE
            && l_q.shift[2:1] == l_q.sel_s2;
    endsequence

    AST_ACK_MATCH: assert property (@(posedge scl_i) disable iff (!reset_n)
        (s_word_end and s_match) |=> sda_oe)
        else $error("matched address word not acknowledged");

    AST_NO_ACK_OTHER: assert property (@(posedge scl_i) disable iff (!reset_n)
        (s_word_end and l_q.shift[6:3] != DEV_TYPE && l_q.shift[6:3] != 4'hf) |=> !sda_oe)
        else $error("foreign address word acknowledged");

    AST_MSB_TAKEN: assert property (@(posedge scl_i) disable iff (!reset_n)
        (l_q.state == nvm_pkg::NVM_DEV && l_q.cnt == `NVM_BIT_ACK && l_q.ack
            && l_q.nxt == nvm_pkg::NVM_MADDR && start_tog_q == l_q.start_ack
            && stop_tog_q == l_q.stop_ack)
        |=> l_q.addr[8] == $past(l_q.pend_msb) && l_q.state == nvm_pkg::NVM_MADDR)
        else $error("memory address msb not captured");

    AST_DATA_ACK: assert property (@(posedge scl_i) disable iff (!reset_n)
        (l_q.state == nvm_pkg::NVM_WR && l_q.cnt == `NVM_BIT_LAST
            && start_tog_q == l_q.start_ack && stop_tog_q == l_q.stop_ack)
        |=> sda_oe ##1 !sda_oe)
        else $error("data byte not acknowledged for one clock");

    AST_INHIBIT: assert property (@(posedge scl_i) disable iff (!reset_n)
        (mem_we |-> !l_q.wp_s2) and (l_q.state == nvm_pkg::NVM_WR && l_q.wp_s2
            && l_q.cnt == `NVM_BIT_ACK && start_tog_q == l_q.start_ack
            && stop_tog_q == l_q.stop_ack |=> $changed(l_q.blk_tog) && $stable(l_q.wr_tog)))
        else $error("write under inhibit");

    AST_WRAP: assert property (@(posedge scl_i) disable iff (!reset_n)
        (mem_we && !l_q.fresh && l_q.addr == `NVM_ADDR_TOP) |=> l_q.addr == `NVM_ADDR_RST)
        else $error("page address did not wrap to zero");

    AST_NACK_RELEASE: assert property (@(posedge scl_i) disable iff (!reset_n)
        (l_q.state == nvm_pkg::NVM_RD && l_q.cnt == `NVM_BIT_ACK && sda_i
            && start_tog_q == l_q.start_ack && stop_tog_q == l_q.stop_ack)
        |=> l_q.state == nvm_pkg::NVM_IDLE && !sda_oe)
        else $error("bus not released after nack");

    AST_ID_RESTART: assert property (@(posedge scl_i) disable iff (!reset_n)
        (l_q.state == nvm_pkg::NVM_ID && l_q.cnt == `NVM_BIT_ACK && !sda_i
            && l_q.id_idx == `NVM_ID_LAST && start_tog_q == l_q.start_ack
            && stop_tog_q == l_q.stop_ack)
        |=> l_q.id_idx == `NVM_ID_FIRST && l_q.tx == ID_BYTE0)
        else $error("identity output did not restart");

endmodule : nvm_i2c_slave
`default_nettype wire

// ### bench/nvm_master_model.sv
// two-wire bus master model that drives the serial clock
`timescale 1ns/1ps
`default_nettype none

module nvm_master_model (
    output var  logic scl,
    output var  logic sda_pull,
    input  wire logic sda
);
    localparam int QUARTER = 40;

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ****************************************
    // bus conditions
    // ****************************************
    // data line only pulled or released
    task automatic start_cond();
        sda_pull = 1'b0;
        #QUARTER scl = 1'b1;
        #QUARTER sda_pull = 1'b1;
        #QUARTER scl = 1'b0;
        #QUARTER;
    endtask : start_cond

    // clock then stands still high
    task automatic stop_cond();
        sda_pull = 1'b1;
        #QUARTER scl = 1'b1;
        #QUARTER sda_pull = 1'b0;
        #QUARTER;
    endtask : stop_cond

    // a one is sent by releasing
    task automatic put_bit(input logic b, output logic r);
        sda_pull = ~b;
        #QUARTER scl = 1'b1;
        #QUARTER r = sda;
        #QUARTER scl = 1'b0;
        #QUARTER;
    endtask : put_bit

    // ****************************************
    // byte transfer
    // ****************************************
    // caller passes last high to nack a read
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], r);
            rx[i] = r;
        end
        put_bit(last, ack);
    endtask : xfer
endmodule : nvm_master_model
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cfg.svh"

module tb_top;
    localparam logic [3:0] DEV_TYPE = 4'hb;  // arbitrary value
    localparam logic [7:0] ID0      = 8'h5a; // arbitrary value
    localparam logic [7:0] ID1      = 8'ha5; // arbitrary value
    localparam logic [7:0] ID2      = 8'h3c; // arbitrary value
    localparam logic [1:0] SEL      = 2'b10;

    logic clk;
    logic reset_n;
    logic scl;
    logic sda_pull;
    wire  sda;
    logic sda_o;
    logic sda_oe;
    logic select_pin_low;
    logic select_pin_high;
    logic write_inhibit;
    logic byte_written;
    logic write_blocked;
    int   err_count;
    int   comparisons;
    int   wr_cnt;
    int   blk_cnt;

    // pull-up: high unless someone pulls low
    assign sda = ~sda_pull & ~(sda_oe & ~sda_o);

    always #50 clk = ~clk;

    nvm_i2c_slave #(.DEV_TYPE(DEV_TYPE), .ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2)) nvm_i2c_slave_i (
        .clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .select_pin_low(select_pin_low), .select_pin_high(select_pin_high), .write_inhibit(write_inhibit),
        .byte_written(byte_written), .write_blocked(write_blocked));

    nvm_master_model nvm_master_model_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    always @(posedge clk) begin
        if (byte_written === 1'b1) wr_cnt++;
        if (write_blocked === 1'b1) blk_cnt++;
    end

    // output moves only while clock low
    always @(sda_oe) begin
        if (reset_n === 1'b1 && scl !== 1'b0) check_bit(scl, 1'b0);
    end

    // ****************************************
    // compare and closing
    // ****************************************
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_count(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_count

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // ****************************************
    // bus helpers
    // ****************************************
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        nvm_master_model_i.xfer(b, 1'b1, rx, ack);
        check_bit(ack, exp_ack);
        check_bit(sda_o, 1'b0);
    endtask : send

    task automatic read_expect(input logic [7:0] exp, input logic last);
        logic [7:0] rx;
        logic       ack;
        nvm_master_model_i.xfer(8'hff, last, rx, ack);
        check_byte(rx, exp);
        if (last) check_bit(sda_oe, 1'b0);
    endtask : read_expect

    // type, select, msb, write, low address
    task automatic set_addr(input logic [8:0] a);
        nvm_master_model_i.start_cond();
        send({DEV_TYPE, SEL, a[8], 1'b0}, 1'b0);
        send(a[7:0], 1'b0);
    endtask : set_addr

    task automatic settle();
        repeat (6) @(negedge clk);
    endtask : settle

    // ****************************************
    // scenarios
    // ****************************************
    task automatic sc_select();
        for (int s = 0; s < 4; s++) begin
            nvm_master_model_i.start_cond();
            send({DEV_TYPE, 2'(s), 1'b0, 1'b0}, 2'(s) != SEL);
            nvm_master_model_i.stop_cond();
        end
        nvm_master_model_i.start_cond();
        send({DEV_TYPE ^ 4'h1, SEL, 1'b0, 1'b0}, 1'b1);
        nvm_master_model_i.stop_cond();
    endtask : sc_select

    task automatic sc_page_write();
        int w0;
        w0 = wr_cnt;
        set_addr(9'h1fe);
        send(8'hc0, 1'b0);
        settle();
        check_count(wr_cnt - w0, 1);
        for (int i = 1; i < 4; i++) send(8'hc0 + 8'(i), 1'b0);
        nvm_master_model_i.stop_cond();
        settle();
        check_count(wr_cnt - w0, 4);
    endtask : sc_page_write

    task automatic sc_reads();
        set_addr(9'h1ff);
        nvm_master_model_i.start_cond();
        send({DEV_TYPE, SEL, 1'b1, 1'b1}, 1'b0);
        read_expect(8'hc1, 1'b0);
        read_expect(8'hc2, 1'b1);
        nvm_master_model_i.stop_cond();
        nvm_master_model_i.start_cond();
        send({DEV_TYPE, SEL, 1'b0, 1'b1}, 1'b0);
        read_expect(8'hc3, 1'b1);
        nvm_master_model_i.stop_cond();
    endtask : sc_reads

    task automatic sc_inhibit();
        int w0;
        int b0;
        w0 = wr_cnt;
        b0 = blk_cnt;
        @(negedge clk) write_inhibit = 1'b1;
        set_addr(9'h1fe);
        send(8'h77, 1'b0);
        nvm_master_model_i.stop_cond();
        settle();
        check_count(wr_cnt - w0, 0);
        check_count(blk_cnt - b0, 1);
        set_addr(9'h1fe);
        nvm_master_model_i.start_cond();
        send({DEV_TYPE, SEL, 1'b1, 1'b1}, 1'b0);
        read_expect(8'hc0, 1'b1);
        nvm_master_model_i.stop_cond();
        @(negedge clk) write_inhibit = 1'b0;
    endtask : sc_inhibit

    task automatic sc_abort();
        int   w0;
        logic r;
        w0 = wr_cnt;
        set_addr(9'h010);
        for (int i = 0; i < 4; i++) nvm_master_model_i.put_bit(1'b0, r);
        nvm_master_model_i.stop_cond();
        settle();
        check_count(wr_cnt - w0, 0);
        check_bit(sda_oe, 1'b0);
    endtask : sc_abort

    task automatic sc_ident();
        nvm_master_model_i.start_cond();
        send(`NVM_ID_READ, 1'b1);
        nvm_master_model_i.stop_cond();
        nvm_master_model_i.start_cond();
        send(`NVM_ID_SETUP, 1'b0);
        send({DEV_TYPE, SEL, 1'b0, 1'b0}, 1'b0);
        nvm_master_model_i.stop_cond();
        nvm_master_model_i.start_cond();
        send(`NVM_ID_READ, 1'b1);
        nvm_master_model_i.stop_cond();
        nvm_master_model_i.start_cond();
        send(`NVM_ID_SETUP, 1'b0);
        send({DEV_TYPE, SEL, 1'b1, 1'b1}, 1'b0);
        nvm_master_model_i.start_cond();
        send(`NVM_ID_READ, 1'b0);
        read_expect(ID0, 1'b0);
        read_expect(ID1, 1'b0);
        read_expect(ID2, 1'b0);
        read_expect(ID0, 1'b1);
        nvm_master_model_i.stop_cond();
    endtask : sc_ident

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk             = 1'b0;
        reset_n         = 1'b0;
        select_pin_high = SEL[1];
        select_pin_low  = SEL[0];
        write_inhibit   = 1'b0;
        err_count       = 0;
        comparisons     = 0;
        wr_cnt          = 0;
        blk_cnt         = 0;
        repeat (8) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        repeat (4) @(negedge clk);
        // no current read before an addressed access
        sc_select();
        sc_page_write();
        sc_reads();
        sc_inhibit();
        sc_abort();
        sc_ident();
        settle();
        stop_test();
    end

    initial begin
        #1000000;
        err_count++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
